// file: rtl/scp_pkg.sv
// Shared constants, types and helpers of the sync, clamp and aux-pin control
package scp_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] SCP_ADDR_PRE_COAST = 8'h11;
  localparam logic [7:0] SCP_ADDR_POST_COAST = 8'h12;
  localparam logic [7:0] SCP_ADDR_MISC = 8'h13;
  localparam logic [7:0] SCP_ADDR_START_HI = 8'h14;
  localparam logic [7:0] SCP_ADDR_START_LO = 8'h15;
  localparam logic [7:0] SCP_ADDR_CLAMP_WIDTH = 8'h16;
  localparam logic [7:0] SCP_ADDR_STATUS = 8'h1e;
  localparam logic [7:0] SCP_ADDR_CTRL = 8'h1f;

  // ==========================================================
  // Reset values
  localparam logic [7:0] SCP_RST_PRE_COAST = 8'h04;
  localparam logic [7:0] SCP_RST_POST_COAST = 8'h04;
  localparam logic [7:0] SCP_RST_MISC = 8'h04;
  localparam logic [4:0] SCP_RST_START_HI = 5'h00;
  localparam logic [7:0] SCP_RST_START_LO = 8'h03;
  localparam logic [7:0] SCP_RST_CLAMP_WIDTH = 8'h10;
  localparam logic [7:0] SCP_RST_CTRL = 8'h06;

  // ==========================================================
  // Field positions
  localparam int SCP_MISC_LOCK1_BIT = 0;
  localparam int SCP_MISC_LOCK2_BIT = 1;
  localparam int SCP_MISC_PIN_DIS_BIT = 3;
  localparam int SCP_MISC_FUNC_LSB = 4;
  localparam int SCP_MISC_XCLK_HALF_BIT = 6;
  localparam int SCP_MISC_XCLK_OFF_BIT = 7;
  localparam int SCP_CTRL_SRC_BIT = 0;
  localparam int SCP_CTRL_DCR_EN_BIT = 1;
  localparam int SCP_CTRL_BLACK_EN_BIT = 2;
  localparam int SCP_START_HI_W = 5;
  localparam int SCP_START_W = 13;
  localparam int SCP_LINE_W = 12;
  localparam int SCP_TMO_W = 23;

  // Narrower widths produce no pulse at all
  localparam logic [7:0] SCP_CLAMP_MIN_WIDTH = 8'h02;

  // ==========================================================
  // Timing
  localparam int unsigned SCP_CLK_FREQ_HZ = 50_000_000;
  localparam int unsigned SCP_UPD_DELAY_MS = 100;
  localparam int unsigned SCP_UPD_DELAY_CYC =
    SCP_UPD_DELAY_MS * (SCP_CLK_FREQ_HZ / 1000);

  // ==========================================================
  // Aux pin roles, in field encoding order
  typedef enum logic [1:0] {
    SCP_AUX_CLK_INVERT,
    SCP_AUX_EXT_CLAMP,
    SCP_AUX_EXT_COAST,
    SCP_AUX_EXT_PIXEL_CLOCK
  } scp_aux_mode_t;

  function automatic logic scp_rise(input logic cur, input logic prev);
    scp_rise = cur & ~prev;
  endfunction

  function automatic logic scp_fall(input logic cur, input logic prev);
    scp_fall = ~cur & prev;
  endfunction

endpackage

// file: rtl/scp_clamp_gen.sv
// Internal clamp pulse generator timed from the sync trailing edge
`timescale 1ns/100ps
`default_nettype none
module scp_clamp_gen
  import scp_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // Timing
  input wire logic trail_in,
  input wire logic [12:0] start_in,
  input wire logic [7:0] width_in,
  // Pulse
  output logic clamp_out
);

  typedef enum logic [1:0] {
    SCP_CLP_IDLE,
    SCP_CLP_COUNT,
    SCP_CLP_PULSE
  } scp_clp_st_t;

  typedef struct packed {
    scp_clp_st_t st;
    logic [12:0] pix;
    logic [7:0] wid;
    logic clamp;
  } scp_clp_state_t;

  scp_clp_state_t s_ff;
  scp_clp_state_t nxt_s;

  // ==========================================================
  // Pixel count and pulse
  always_comb
  begin
    nxt_s = s_ff;
    case (s_ff.st)
      SCP_CLP_IDLE:
      begin
        if (trail_in)
        begin
          nxt_s.pix = 13'h0000;
          nxt_s.st = SCP_CLP_COUNT;
        end
      end
      SCP_CLP_COUNT:
      begin
        if (trail_in)
        begin
          nxt_s.pix = 13'h0000;
        end
        else if (s_ff.pix == start_in)
        begin
          if (width_in >= SCP_CLAMP_MIN_WIDTH)
          begin
            nxt_s.clamp = 1'b1;
            nxt_s.wid = width_in - 8'h01;
            nxt_s.st = SCP_CLP_PULSE;
          end
          else
          begin
            nxt_s.st = SCP_CLP_IDLE;
          end
        end
        else
        begin
          nxt_s.pix = s_ff.pix + 13'h0001;
        end
      end
      SCP_CLP_PULSE:
      begin
        if (s_ff.wid == 8'h00)
        begin
          nxt_s.clamp = 1'b0;
          nxt_s.st = SCP_CLP_IDLE;
        end
        else
        begin
          nxt_s.wid = s_ff.wid - 8'h01;
        end
      end
      default:
      begin
        nxt_s.clamp = 1'b0;
        nxt_s.st = SCP_CLP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      s_ff <= '0;
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

  assign clamp_out = s_ff.clamp;

  // ==========================================================
  // Checks
  logic [7:0] chk_len_ff;
  logic [7:0] chk_wid_ff;

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      chk_len_ff <= 8'h00;
      chk_wid_ff <= 8'h00;
    end
    else if (nxt_s.clamp && !s_ff.clamp)
    begin
      chk_len_ff <= 8'h01;
      chk_wid_ff <= width_in;
    end
    else if (s_ff.clamp)
    begin
      chk_len_ff <= chk_len_ff + 8'h01;
    end
  end

  property p_clamp_len;
    @(posedge clk_in) disable iff (!rstn_in)
    $fell(clamp_out) |-> $past(chk_len_ff) == chk_wid_ff;
  endproperty
  a_clamp_len: assert property (p_clamp_len)
    else $error("clamp pulse length differs from width");

  property p_clamp_min;
    @(posedge clk_in) disable iff (!rstn_in)
    $rose(clamp_out) |-> $past(width_in) >= SCP_CLAMP_MIN_WIDTH;
  endproperty
  a_clamp_min: assert property (p_clamp_min)
    else $error("clamp pulse with width below minimum");

  property p_clamp_start;
    @(posedge clk_in) disable iff (!rstn_in)
    $rose(clamp_out) |-> $past(s_ff.pix) == $past(start_in);
  endproperty
  a_clamp_start: assert property (p_clamp_start)
    else $error("clamp started away from start pixel");

endmodule // scp_clamp_gen
`default_nettype wire

// file: rtl/scp_xclk_gen.sv
// Crystal clock output: full rate, half rate or held low
`timescale 1ns/100ps
`default_nettype none
module scp_xclk_gen
  import scp_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // Crystal square wave pin and controls
  input wire logic xtal_in,
  input wire logic half_in,
  input wire logic off_in,
  // Output
  output logic crystal_clock_out
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic prev;
    logic half;
    logic out;
  } scp_xclk_state_t;

  scp_xclk_state_t s_ff;
  scp_xclk_state_t nxt_s;

  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.s1 = xtal_in;
    nxt_s.s2 = s_ff.s1;
    nxt_s.prev = s_ff.s2;
    if (scp_rise(s_ff.s2, s_ff.prev))
    begin
      nxt_s.half = ~s_ff.half;
    end
    if (off_in)
    begin
      nxt_s.out = 1'b0;
    end
    else if (half_in)
    begin
      nxt_s.out = s_ff.half;
    end
    else
    begin
      nxt_s.out = s_ff.s2;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      s_ff <= '0;
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

  assign crystal_clock_out = s_ff.out;

  property p_xclk_off;
    @(posedge clk_in) disable iff (!rstn_in)
    off_in |=> !crystal_clock_out;
  endproperty
  a_xclk_off: assert property (p_xclk_off)
    else $error("crystal output not low while disabled");

  property p_xclk_half;
    @(posedge clk_in) disable iff (!rstn_in)
    (!off_in && half_in) |=> crystal_clock_out == $past(s_ff.half);
  endproperty
  a_xclk_half: assert property (p_xclk_half)
    else $error("crystal output not at half rate");

endmodule // scp_xclk_gen
`default_nettype wire

// file: rtl/scp_aux_ctrl.sv
// Sync edge select, aux pin function, clamp, coast and register control
// Operation
// - First sync locks on its trailing edge when its edge bit is 0, else leading.
// - Second sync locks on its trailing edge when its edge bit is 0, else leading.
// - With the pin disable bit set the aux pin reads as low, otherwise it is used.
// - Two function bits pick the pin role: clock invert, clamp, coast, pixel clock.
// - Each clamp pulse fires DC restore and black-level start when enabled and always updates offsets.
// - Outside external clamp mode the clamp pulse is made internally every line.
// - In external clamp mode offsets change at the external pulse's leading edge.
// - Without a clamp pulse a gain or offset write takes effect after a 100 ms timeout.
// - Crystal output runs at crystal rate with its rate bit 0, half rate with 1.
// - With its disable bit 1 the crystal output is held low.
// - A 13-bit start pixel after the sync trailing edge begins restore and black-level work.
// - The start pixel is five upper bits in one register and eight lower in the next.
// - The clamp width sets the restore pulse length and does not touch black-level work.
// - A clamp width of 0 or 1 produces no clamp pulse.
// - Coast holds the loop for programmed line counts before and after vertical sync.
//
// Local design decision: strobed register access.
`timescale 1ns/100ps
`default_nettype none
module scp_aux_ctrl
  import scp_pkg::*;
#(
  parameter int unsigned UPD_DELAY_CYCLES = SCP_UPD_DELAY_CYC
)
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // Register port
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  // Pins
  input wire logic first_hsync_input_in,
  input wire logic second_hsync_input_in,
  input wire logic vsync_in,
  input wire logic aux_function_pin_in,
  input wire logic xtal_in,
  // Gain or offset register written elsewhere
  input wire logic gain_offset_write_in,
  // Loop and analog controls
  output logic lock_pulse_out,
  output logic sample_clock_invert_out,
  output logic external_pixel_clock_sel_out,
  output logic coast_out,
  output logic clamp_out,
  output logic dc_restore_out,
  output logic auto_black_level_comp_start_out,
  output logic offset_update_out,
  output logic crystal_clock_output_out
);

  typedef struct packed {
    logic [7:0] pre;
    logic [7:0] post;
    logic [7:0] misc;
    logic [4:0] start_hi;
    logic [7:0] start_lo;
    logic [7:0] width;
    logic [7:0] ctrl;
    logic [7:0] rdata;
    logic [2:0] h1;
    logic [2:0] h2;
    logic [2:0] aux;
    logic [2:0] vs;
    logic lock;
    logic inv;
    logic pix_sel;
    logic [SCP_LINE_W-1:0] line_cnt;
    logic [SCP_LINE_W-1:0] frame_lines;
    logic [7:0] post_cnt;
    logic coast;
    logic clamp;
    logic dcr;
    logic black_start;
    logic upd;
    logic pending;
    logic [SCP_TMO_W-1:0] tmo;
  } scp_ctrl_state_t;

  scp_ctrl_state_t s_ff;
  scp_ctrl_state_t nxt_s;

  logic int_clamp;
  logic src2;
  logic sel_cur;
  logic sel_prev;
  logic lead;
  logic trail;
  logic lock_bit;
  logic aux_eff;
  scp_aux_mode_t mode;
  logic clamp_lvl;
  logic clamp_rise;
  logic pre_act;
  logic [12:0] line_sum;
  logic [12:0] start_pix;

  // ==========================================================
  // Decode of sync, pin and clamp source
  always_comb
  begin
    src2 = s_ff.ctrl[SCP_CTRL_SRC_BIT];
    // Bit 1 of each chain is the second sync stage, bit 2 its history
    sel_cur = src2 ? s_ff.h2[1] : s_ff.h1[1];
    sel_prev = src2 ? s_ff.h2[2] : s_ff.h1[2];
    lead = scp_rise(sel_cur, sel_prev);
    trail = scp_fall(sel_cur, sel_prev);
    lock_bit = src2 ? s_ff.misc[SCP_MISC_LOCK2_BIT]
                    : s_ff.misc[SCP_MISC_LOCK1_BIT];
    aux_eff = s_ff.aux[1] & ~s_ff.misc[SCP_MISC_PIN_DIS_BIT];
    mode = scp_aux_mode_t'(s_ff.misc[SCP_MISC_FUNC_LSB +: 2]);
    clamp_lvl = (mode == SCP_AUX_EXT_CLAMP) ? aux_eff : int_clamp;
    clamp_rise = scp_rise(clamp_lvl, s_ff.clamp);
    start_pix = {s_ff.start_hi, s_ff.start_lo};
    line_sum = {1'b0, s_ff.line_cnt} + {5'h00, s_ff.pre};
    pre_act = (s_ff.frame_lines != '0)
      && (line_sum >= {1'b0, s_ff.frame_lines});
  end

  scp_clamp_gen u_clamp_gen (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .trail_in(trail),
    .start_in(start_pix),
    .width_in(s_ff.width),
    .clamp_out(int_clamp)
  );

  scp_xclk_gen u_xclk_gen (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .xtal_in(xtal_in),
    .half_in(s_ff.misc[SCP_MISC_XCLK_HALF_BIT]),
    .off_in(s_ff.misc[SCP_MISC_XCLK_OFF_BIT]),
    .crystal_clock_out(crystal_clock_output_out)
  );

  // ==========================================================
  // Next state
  always_comb
  begin
    nxt_s = s_ff;
    // Two stages before any use, third is edge history
    nxt_s.h1 = {s_ff.h1[1:0], first_hsync_input_in};
    nxt_s.h2 = {s_ff.h2[1:0], second_hsync_input_in};
    nxt_s.aux = {s_ff.aux[1:0], aux_function_pin_in};
    nxt_s.vs = {s_ff.vs[1:0], vsync_in};

    // Register writes
    if (wr_in)
    begin
      case (addr_in)
        SCP_ADDR_PRE_COAST: nxt_s.pre = wdata_in;
        SCP_ADDR_POST_COAST: nxt_s.post = wdata_in;
        SCP_ADDR_MISC: nxt_s.misc = wdata_in;
        SCP_ADDR_START_HI: nxt_s.start_hi = wdata_in[SCP_START_HI_W-1:0];
        SCP_ADDR_START_LO: nxt_s.start_lo = wdata_in;
        SCP_ADDR_CLAMP_WIDTH: nxt_s.width = wdata_in;
        SCP_ADDR_CTRL: nxt_s.ctrl = {5'h00, wdata_in[2:0]};
        default: nxt_s.ctrl = s_ff.ctrl;
      endcase
    end

    // Register reads, unmapped reads zero
    nxt_s.rdata = 8'h00;
    if (rd_in)
    begin
      case (addr_in)
        SCP_ADDR_PRE_COAST: nxt_s.rdata = s_ff.pre;
        SCP_ADDR_POST_COAST: nxt_s.rdata = s_ff.post;
        SCP_ADDR_MISC: nxt_s.rdata = s_ff.misc;
        SCP_ADDR_START_HI: nxt_s.rdata = {3'h0, s_ff.start_hi};
        SCP_ADDR_START_LO: nxt_s.rdata = s_ff.start_lo;
        SCP_ADDR_CLAMP_WIDTH: nxt_s.rdata = s_ff.width;
        SCP_ADDR_STATUS:
          nxt_s.rdata = {2'h0, mode, aux_eff, s_ff.pending,
                         s_ff.coast, s_ff.clamp};
        SCP_ADDR_CTRL: nxt_s.rdata = s_ff.ctrl;
        default: nxt_s.rdata = 8'h00;
      endcase
    end

    // second input has its own bit
    nxt_s.lock = lock_bit ? lead : trail;

    nxt_s.inv = (mode == SCP_AUX_CLK_INVERT) & aux_eff;
    nxt_s.pix_sel = (mode == SCP_AUX_EXT_PIXEL_CLOCK)
      & ~s_ff.misc[SCP_MISC_PIN_DIS_BIT];

    // line count, pre and post coast
    if (scp_rise(s_ff.vs[1], s_ff.vs[2]))
    begin
      nxt_s.frame_lines = s_ff.line_cnt;
      nxt_s.line_cnt = '0;
    end
    else if (lead && s_ff.line_cnt != '1)
    begin
      nxt_s.line_cnt = s_ff.line_cnt + 12'h001;
    end
    if (scp_fall(s_ff.vs[1], s_ff.vs[2]))
    begin
      nxt_s.post_cnt = s_ff.post;
    end
    else if (lead && s_ff.post_cnt != 8'h00)
    begin
      nxt_s.post_cnt = s_ff.post_cnt - 8'h01;
    end
    if (mode == SCP_AUX_EXT_COAST)
    begin
      nxt_s.coast = aux_eff;
    end
    else
    begin
      // Next count, so coast has no gap as vertical sync ends
      nxt_s.coast = s_ff.vs[1] | (nxt_s.post_cnt != 8'h00) | pre_act;
    end

    nxt_s.clamp = clamp_lvl;
    nxt_s.dcr = clamp_lvl & s_ff.ctrl[SCP_CTRL_DCR_EN_BIT];
    nxt_s.black_start = clamp_rise & s_ff.ctrl[SCP_CTRL_BLACK_EN_BIT];
    nxt_s.upd = 1'b0;

    if (clamp_rise)
    begin
      nxt_s.upd = 1'b1;
      nxt_s.pending = 1'b0;
      nxt_s.tmo = '0;
    end
    else if (s_ff.pending)
    begin
      if (s_ff.tmo >= SCP_TMO_W'(UPD_DELAY_CYCLES - 1))
      begin
        nxt_s.upd = 1'b1;
        nxt_s.pending = 1'b0;
        nxt_s.tmo = '0;
      end
      else
      begin
        nxt_s.tmo = s_ff.tmo + 1'b1;
      end
    end
    // A write beside a clamp still waits for the next one
    if (gain_offset_write_in)
    begin
      nxt_s.pending = 1'b1;
      nxt_s.tmo = '0;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      s_ff <= '0;
      s_ff.pre <= SCP_RST_PRE_COAST;
      s_ff.post <= SCP_RST_POST_COAST;
      s_ff.misc <= SCP_RST_MISC;
      s_ff.start_hi <= SCP_RST_START_HI;
      s_ff.start_lo <= SCP_RST_START_LO;
      s_ff.width <= SCP_RST_CLAMP_WIDTH;
      s_ff.ctrl <= SCP_RST_CTRL;
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

  assign rdata_out = s_ff.rdata;
  assign lock_pulse_out = s_ff.lock;
  assign sample_clock_invert_out = s_ff.inv;
  assign external_pixel_clock_sel_out = s_ff.pix_sel;
  assign coast_out = s_ff.coast;
  assign clamp_out = s_ff.clamp;
  assign dc_restore_out = s_ff.dcr;
  assign auto_black_level_comp_start_out = s_ff.black_start;
  assign offset_update_out = s_ff.upd;

  // ==========================================================
  // Checks
  sequence s_trail1;
    !src2 && !s_ff.misc[SCP_MISC_LOCK1_BIT] && trail;
  endsequence

  property p_lock1;
    @(posedge clk_in) disable iff (!rstn_in)
    s_trail1 |=> lock_pulse_out;
  endproperty
  a_lock1: assert property (p_lock1)
    else $error("no lock pulse on first sync trailing edge");

  property p_lock2;
    @(posedge clk_in) disable iff (!rstn_in)
    (src2 && s_ff.misc[SCP_MISC_LOCK2_BIT] && lead) |=> lock_pulse_out;
  endproperty
  a_lock2: assert property (p_lock2)
    else $error("no lock pulse on second sync leading edge");

  property p_pin_dis;
    @(posedge clk_in) disable iff (!rstn_in)
    s_ff.misc[SCP_MISC_PIN_DIS_BIT] |=> !sample_clock_invert_out;
  endproperty
  a_pin_dis: assert property (p_pin_dis)
    else $error("disabled aux pin still inverts clock");

  sequence s_ext_rise;
    (mode == SCP_AUX_EXT_CLAMP) && !aux_eff ##1
    (mode == SCP_AUX_EXT_CLAMP) && aux_eff;
  endsequence

  property p_ext_upd;
    @(posedge clk_in) disable iff (!rstn_in)
    s_ext_rise |=> offset_update_out ##1 !offset_update_out;
  endproperty
  a_ext_upd: assert property (p_ext_upd)
    else $error("offset update missing at external clamp edge");

  property p_upd_cause;
    @(posedge clk_in) disable iff (!rstn_in)
    offset_update_out |-> $past(clamp_rise) || $past(s_ff.pending);
  endproperty
  a_upd_cause: assert property (p_upd_cause)
    else $error("offset update without clamp or pending write");

  property p_coast_vs;
    @(posedge clk_in) disable iff (!rstn_in)
    (mode != SCP_AUX_EXT_COAST) && s_ff.vs[1] |=> coast_out;
  endproperty
  a_coast_vs: assert property (p_coast_vs)
    else $error("loop not coasting during vertical sync");

  property p_post_coast;
    @(posedge clk_in) disable iff (!rstn_in)
    (mode != SCP_AUX_EXT_COAST) && (s_ff.post != 8'h00)
      && scp_fall(s_ff.vs[1], s_ff.vs[2]) |=> coast_out;
  endproperty
  a_post_coast: assert property (p_post_coast)
    else $error("loop not coasting right after vertical sync");

endmodule // scp_aux_ctrl
`default_nettype wire

// file: tb/scp_src.sv
// Video source model: sync pulses, aux pin, vertical sync, crystal
`timescale 1ns/100ps
`default_nettype none
module scp_src
(
  // Clock
  input wire logic clk_in,
  // Pins
  output logic hs1_out,
  output logic hs2_out,
  output logic vsync_out,
  output logic aux_out,
  output logic xtal_out
);
  int n = 0;
  initial
  begin
    hs1_out = 1'b0;
    hs2_out = 1'b0;
    vsync_out = 1'b0;
    aux_out = 1'b0;
    xtal_out = 1'b0;
  end
  // Crystal runs free, unrelated in phase to the pixel clock
  always #103 xtal_out = ~xtal_out;
  always @(posedge clk_in) n <= n + 1;
  // ==========================================================
  // Pulse on pin sel (0, 1 syncs, 2 aux); reports launch edges
  task automatic pulse(input int sel, input int hi, output int lead,
                       output int trail);
    @(posedge clk_in);
    lead = n + 1;
    case (sel)
      0: hs1_out <= 1'b1;
      1: hs2_out <= 1'b1;
      default: aux_out <= 1'b1;
    endcase
    repeat (hi) @(posedge clk_in);
    trail = n + 1;
    hs1_out <= 1'b0;
    hs2_out <= 1'b0;
    aux_out <= 1'b0;
  endtask
  task automatic level(input logic a, input logic v);
    @(posedge clk_in);
    aux_out <= a;
    vsync_out <= v;
  endtask
endmodule // scp_src
`default_nettype wire

// file: tb/tb_top.sv
// Self-checking bench of the sync, clamp and aux-pin control
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import scp_pkg::*;
;
  localparam int UPD = 20;
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [7:0] addr_in = 8'h00;
  logic [7:0] wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic gow_in = 1'b0;
  logic [7:0] rdata_out;
  logic hs1, hs2, vs, aux, xtal, clamp_q, xclk_q;
  logic lock_o, inv_o, pix_o, coast_o, clamp_o, dcr_o, black_o, upd_o, xclk_o;
  int failures = 0;
  int check_count = 0;
  int cyc = 0;
  int lock_cyc, rise_cyc, upd_cyc, black_cyc;
  int locks, rises, high_n, upd_n, dcr_n, tog_n;

  always #10 clk_in = ~clk_in;
  always @(posedge clk_in) cyc <= cyc + 1;

  scp_src u_src (.clk_in(clk_in), .hs1_out(hs1), .hs2_out(hs2),
    .vsync_out(vs), .aux_out(aux), .xtal_out(xtal));

  scp_aux_ctrl #(.UPD_DELAY_CYCLES(UPD)) u_dut (
    .clk_in(clk_in), .rstn_in(rstn_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .first_hsync_input_in(hs1),
    .second_hsync_input_in(hs2), .vsync_in(vs),
    .aux_function_pin_in(aux), .xtal_in(xtal),
    .gain_offset_write_in(gow_in), .lock_pulse_out(lock_o),
    .sample_clock_invert_out(inv_o),
    .external_pixel_clock_sel_out(pix_o), .coast_out(coast_o),
    .clamp_out(clamp_o), .dc_restore_out(dcr_o),
    .auto_black_level_comp_start_out(black_o),
    .offset_update_out(upd_o),
    .crystal_clock_output_out(xclk_o));

  // ==========================================================
  // Monitor, sampled mid-cycle where outputs are settled
  always @(negedge clk_in)
  begin
    if (lock_o === 1'b1) lock_cyc = cyc;
    if (clamp_o === 1'b1 && clamp_q !== 1'b1) rise_cyc = cyc;
    if (upd_o === 1'b1) upd_cyc = cyc;
    if (black_o === 1'b1) black_cyc = cyc;
    locks += int'(lock_o === 1'b1);
    rises += int'(clamp_o === 1'b1 && clamp_q !== 1'b1);
    high_n += int'(clamp_o === 1'b1);
    upd_n += int'(upd_o === 1'b1);
    dcr_n += int'(dcr_o === 1'b1);
    tog_n += int'(xclk_o !== xclk_q);
    clamp_q = clamp_o;
    xclk_q = xclk_o;
  end

  task automatic clear();
    {locks, rises, high_n, upd_n, dcr_n, tog_n} = '0;
    lock_cyc = -1;
    rise_cyc = -1;
    upd_cyc = -1;
    black_cyc = -1;
  endtask

  // ==========================================================
  // Register port and comparisons
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chkn(input int got, input int exp);
    check_count++;
    if (got != exp)
    begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    chk8(rdata_out, exp);
  endtask
  function automatic logic [7:0] misc(input logic off, half,
    input logic [1:0] role, input logic dis, e2, e1);
    return {off, half, role, dis, 1'b0, e2, e1};
  endfunction
  function automatic int near(input int got, input int exp);
    return int'(got >= exp - 3 && got <= exp + 3);
  endfunction
  task automatic conclude();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    #1000000;
    failures++;
    conclude();
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    int s, w, e1, e2, sel, t0, t1, i, a, r, d;
    void'($urandom(32'hfaf6));
    repeat (12) @(posedge clk_in);
    rstn_in <= 1'b1;
    rchk(SCP_ADDR_MISC, 8'h04);
    rchk(SCP_ADDR_START_HI, 8'h00);
    rchk(SCP_ADDR_START_LO, 8'h03);
    rchk(SCP_ADDR_CLAMP_WIDTH, 8'h10);
    rchk(SCP_ADDR_POST_COAST, 8'h04);
    rchk(SCP_ADDR_CTRL, 8'h06);
    rchk(8'h40, 8'h00);
    wr(SCP_ADDR_START_HI, 8'hff);
    rchk(SCP_ADDR_START_HI, 8'h1f);
    // Lines with random edge, source, start and width
    for (i = 0; i < 10; i++)
    begin
      sel = $urandom % 2;
      e1 = $urandom % 2;
      e2 = $urandom % 2;
      w = (i < 3) ? i : 2 + $urandom % 23;
      s = (i == 3) ? 'h105 : $urandom % 40;
      wr(SCP_ADDR_CTRL, 8'(8'h06 | sel));
      wr(SCP_ADDR_MISC, misc(0, 0, 2'b00, 0, e2[0], e1[0]));
      wr(SCP_ADDR_START_HI, 8'(s >> 8));
      wr(SCP_ADDR_START_LO, 8'(s));
      wr(SCP_ADDR_CLAMP_WIDTH, 8'(w));
      clear();
      u_src.pulse(sel, 8, t0, t1);
      repeat (s + w + 16) @(posedge clk_in);
      chkn(locks, 1);
      chkn(lock_cyc, ((sel ? e2 : e1) ? t0 : t1) + 3);
      chkn(high_n, (w < 2) ? 0 : w);
      chkn(upd_n, int'(w >= 2));
      if (w >= 2)
      begin
        chkn(rise_cyc, t1 + 5 + s);
        chkn(upd_cyc, rise_cyc);
        chkn(black_cyc, rise_cyc);
        chkn(dcr_n, w);
      end
    end
    // Aux pin role and disable
    for (i = 0; i < 8; i++)
    begin
      a = $urandom % 2;
      r = i / 2;
      d = i % 2;
      u_src.level(a[0], 1'b0);
      wr(SCP_ADDR_MISC, misc(0, 0, 2'(r), d[0], 0, 0));
      repeat (8) @(posedge clk_in);
      #1;
      chk8(8'(inv_o), 8'(r == 0 && d == 0 && a == 1));
      chk8(8'(pix_o), 8'(r == 3 && d == 0));
      if (r == 2) chk8(8'(coast_o), 8'(d == 0 && a == 1));
    end
    // External clamp: only the pin makes a clamp
    u_src.level(1'b0, 1'b0);
    wr(SCP_ADDR_CTRL, 8'h06);
    wr(SCP_ADDR_MISC, misc(0, 0, 2'b01, 0, 0, 0));
    repeat (8) @(posedge clk_in);
    clear();
    u_src.pulse(0, 8, t0, t1);
    repeat (40) @(posedge clk_in);
    chkn(rises, 0);
    u_src.pulse(2, 5, t0, t1);
    repeat (12) @(posedge clk_in);
    chkn(high_n, 5);
    chkn(upd_n, 1);
    chkn(upd_cyc, t0 + 3);
    // Pin disabled in clamp role: update after the timeout
    wr(SCP_ADDR_MISC, misc(0, 0, 2'b01, 1, 0, 0));
    repeat (4) @(posedge clk_in);
    clear();
    @(posedge clk_in);
    gow_in <= 1'b1;
    t0 = cyc + 1;
    @(posedge clk_in);
    gow_in <= 1'b0;
    repeat (UPD + 10) @(posedge clk_in);
    chkn(upd_n, 1);
    chkn(int'(upd_cyc >= t0 + UPD && upd_cyc <= t0 + UPD + 4), 1);
    // Crystal output: off, full and half rate
    for (i = 0; i < 3; i++)
    begin
      wr(SCP_ADDR_MISC, misc(i == 0, i == 2, 2'b00, 0, 0, 0));
      repeat (6) @(posedge clk_in);
      clear();
      repeat (200) @(posedge clk_in);
      if (i == 0) chkn(tog_n + int'(xclk_o !== 1'b0), 0);
      else chkn(near(tog_n, (i == 1) ? 39 : 19), 1);
    end
    // Vertical sync forces coast, post-coast lasts four leading edges
    wr(SCP_ADDR_PRE_COAST, 8'h00);
    rchk(SCP_ADDR_PRE_COAST, 8'h00);
    u_src.level(1'b0, 1'b1);
    repeat (6) @(posedge clk_in);
    #1;
    chk8(8'(coast_o), 8'h01);
    u_src.level(1'b0, 1'b0);
    for (i = 0; i < 4; i++)
    begin
      u_src.pulse(0, 2, t0, t1);
      repeat (4) @(posedge clk_in);
      #1;
      chk8(8'(coast_o), 8'(i < 3));
    end
    conclude();
  end
endmodule // tb_top
`default_nettype wire
